// File: core/tmrirq_flag.sv
// one sticky event flag with w1c and vector-acknowledge clear
`timescale 1ns/1ps
module tmrirq_flag
(
  input  wire logic ref_clk_i,
  input  wire logic nrst_i,
  input  wire logic set_i,   // hardware event
  input  wire logic clr_i,   // write-one or acknowledge
  output logic      flag_o
);
  // ---------------------------------------------------------------
  // flag storage
  // ---------------------------------------------------------------
  wire logic next_flag = set_i | (flag_o & ~clr_i); // set beats clear

  // registered flag
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      flag_o <= 1'b0;
    else
      flag_o <= next_flag;
  end

  AST_SET_WINS: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    set_i |=> flag_o) else $error("flag lost on simultaneous set");
endmodule

// File: core/tmrirq_pkg.sv
// package: register map, bit positions and carriers for the timer irq flag block
package tmrirq_pkg;

  // ---------------------------------------------------------------
  // register byte offsets on the axi4-lite bus
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_FLAGS   = 8'h00; // timer_event_flags, w1c
  localparam logic [7:0] OFS_ENABLES = 8'h04; // timer_event_enables
  localparam logic [7:0] OFS_CTRL    = 8'h08; // global irq flag + waveform mode
  localparam logic [7:0] OFS_STATUS  = 8'h0C; // pending vector view

  // ---------------------------------------------------------------
  // bit positions shared by flags and enables
  // ---------------------------------------------------------------
  localparam int BIT_OVF  = 0;
  localparam int BIT_CMPA = 1;
  localparam int BIT_CMPB = 2;
  localparam int BIT_CAPT = 5;
  localparam logic [7:0] FLAG_MASK  = 8'h27; // implemented bits only
  localparam logic [7:0] FLAGS_RST  = 8'h00;
  localparam logic [7:0] ENABLE_RST = 8'h00;

  // ctrl register fields
  localparam int CTRL_GIE    = 0;     // global interrupt flag
  localparam int CTRL_WGM_LO = 4;     // waveform_mode_select [7:4]
  localparam logic [4:0] CTRL_MASK  = 5'h1F;
  localparam logic [4:0] CTRL_RST   = 5'h00;

  // waveform modes that raise overflow on counter wrap
  localparam logic [3:0] WGM_NORMAL   = 4'h0;
  localparam logic [3:0] WGM_CTC_OCRA = 4'h4;
  localparam logic [3:0] WGM_CTC_ICR  = 4'hC;
  // modes where capture_register is top
  localparam logic [3:0] WGM_PFC_ICR  = 4'h8;
  localparam logic [3:0] WGM_PC_ICR   = 4'hA;
  localparam logic [3:0] WGM_FAST_ICR = 4'hE;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // events from the timer datapath, one cycle pulses
  typedef struct packed {
    logic capt_pin;  // qualified capture edge
    logic at_top;    // counter equals top this cycle
    logic cmp_a_eq;  // counter_value == compare_a_register
    logic cmp_b_eq;  // counter_value == compare_b_register
    logic wrap;      // counter overflow
    logic at_bottom; // counter reached bottom
  } tmrirq_evt_t;

  // vector acknowledge from the core, one cycle pulses
  typedef struct packed {
    logic capt;
    logic cmp_b;
    logic cmp_a;
    logic ovf;
  } tmrirq_ack_t;

endpackage

// File: core/tmrirq_top.sv
// top: timer irq flags, enables, vector requests and axi4-lite slave
// ---------------------------------------------------------------
// Functional notes
// - compare-A vector needs enable, global, flag
// - overflow vector needs enable, global, flag
// - capture pin event sets capture flag bit5
// - capture-top mode sets capture flag at top
// - vector execute or write-one clears flag
// - compare-B flag set cycle after match
// - compare-A flag set cycle after match
// - forced compare strobes never set flags
// - overflow flag on wrap in normal/ctc
// - bits 7,6,4,3 read zero, ignore writes
// - capture vector needs enable, global, flag
// - compare-B vector needs enable, global, flag
// ---------------------------------------------------------------
`timescale 1ns/1ps
module tmrirq_top
(
  input  wire logic                   ref_clk_i,
  input  wire logic                   nrst_i,
  // timer datapath events
  input  wire tmrirq_pkg::tmrirq_evt_t evt_i,
  input  wire logic                   force_cmp_a_strobe_i,
  input  wire logic                   force_cmp_b_strobe_i,
  // processor core
  input  wire tmrirq_pkg::tmrirq_ack_t ack_i,
  output tmrirq_pkg::tmrirq_ack_t     vec_req_o,
  output logic                        irq_o,
  // axi4-lite slave
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]  enables;   // timer_event_enables
  logic [4:0]  ctrl;      // gie + waveform mode
  logic [7:0]  aw_addr;   // latched write address
  logic [31:0] w_data;    // latched write data
  logic [3:0]  w_strb;    // latched strobes
  logic        aw_held;   // address captured
  logic        w_held;    // data captured
  logic [3:0]  flags4;    // capt, cmpb, cmpa, ovf

  // ---------------------------------------------------------------
  // write channel: accept aw and w in any order
  // ---------------------------------------------------------------
  // only byte lane 0 matters; upper lanes are dropped
  wire logic aw_take = s_axi_awvalid & s_axi_awready;
  wire logic w_take  = s_axi_wvalid & s_axi_wready;
  wire logic wr_go   = aw_held & w_held & ~s_axi_bvalid;
  wire logic wr_flg  = wr_go & (aw_addr == tmrirq_pkg::OFS_FLAGS) & w_strb[0];
  wire logic wr_en   = wr_go & (aw_addr == tmrirq_pkg::OFS_ENABLES) & w_strb[0];
  wire logic wr_ctl  = wr_go & (aw_addr == tmrirq_pkg::OFS_CTRL) & w_strb[0];
  wire logic wr_hit  = (aw_addr == tmrirq_pkg::OFS_FLAGS)
                     | (aw_addr == tmrirq_pkg::OFS_ENABLES)
                     | (aw_addr == tmrirq_pkg::OFS_CTRL)
                     | (aw_addr == tmrirq_pkg::OFS_STATUS);

  // channel handshakes; one write in flight
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= tmrirq_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= ~aw_held & ~aw_take & ~s_axi_bvalid;
      s_axi_wready  <= ~w_held & ~w_take & ~s_axi_bvalid;
      // address kept word aligned
      if (aw_take)
      begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      // data and strobes held until commit
      if (w_take)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      // both halves present: commit and respond
      if (wr_go)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? tmrirq_pkg::RESP_OKAY : tmrirq_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // enables and control registers
  // ---------------------------------------------------------------
  // reserved enable bits stay zero
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      enables <= tmrirq_pkg::ENABLE_RST;
      ctrl    <= tmrirq_pkg::CTRL_RST;
    end
    else
    begin
      // software writes land in the commit cycle
      if (wr_en)
        enables <= w_data[7:0] & tmrirq_pkg::FLAG_MASK;
      if (wr_ctl)
        ctrl <= {w_data[7:4], w_data[0]} & tmrirq_pkg::CTRL_MASK;
    end
  end

  // control fields: bit 0 global, bits 4:1 mode
  wire logic       gie = ctrl[0];
  wire logic [3:0] wgm = ctrl[4:1];

  // ---------------------------------------------------------------
  // event qualification
  // ---------------------------------------------------------------
  // capture_register as top disconnects the pin
  wire logic icr_top = (wgm == tmrirq_pkg::WGM_CTC_ICR) | (wgm == tmrirq_pkg::WGM_PFC_ICR)
                     | (wgm == tmrirq_pkg::WGM_PC_ICR)  | (wgm == tmrirq_pkg::WGM_FAST_ICR);
  wire logic capt_evt = icr_top ? evt_i.at_top : evt_i.capt_pin;
  // normal and ctc flag on wrap; pwm modes use their own timing
  wire logic wrap_mode = (wgm == tmrirq_pkg::WGM_NORMAL) | (wgm == tmrirq_pkg::WGM_CTC_OCRA)
                       | (wgm == tmrirq_pkg::WGM_CTC_ICR);
  // phase-correct modes flag overflow at bottom
  wire logic pc_mode   = (wgm[3:2] == 2'b10) | (wgm[3:0] == 4'h1) | (wgm[3:0] == 4'h2)
                       | (wgm[3:0] == 4'h3);
  wire logic ovf_evt   = wrap_mode ? evt_i.wrap
                       : (pc_mode ? evt_i.at_bottom : evt_i.at_top);

  // match is registered so the flag rises the cycle after equality
  logic cmp_a_d;
  logic cmp_b_d;
  // force strobes are not inputs to this path
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cmp_a_d <= 1'b0;
      cmp_b_d <= 1'b0;
    end
    else
    begin
      cmp_a_d <= evt_i.cmp_a_eq;
      cmp_b_d <= evt_i.cmp_b_eq;
    end
  end

  // ---------------------------------------------------------------
  // sticky flags, one instance per implemented bit
  // ---------------------------------------------------------------
  wire logic [3:0] set_v = {capt_evt, cmp_b_d, cmp_a_d, ovf_evt};
  // write-one clear; zero bits leave the flag alone
  wire logic [3:0] w1c_v = {4{wr_flg}} & {w_data[tmrirq_pkg::BIT_CAPT],
                                          w_data[tmrirq_pkg::BIT_CMPB],
                                          w_data[tmrirq_pkg::BIT_CMPA],
                                          w_data[tmrirq_pkg::BIT_OVF]};
  wire logic [3:0] ack_v = ack_i; // each ack clears its own flag
  // any clear source; set still wins in the flag
  wire logic [3:0] clr_v = w1c_v | ack_v;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_flag
      tmrirq_flag u_flag
      (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .set_i     (set_v[gi]),
        .clr_i     (clr_v[gi]),
        .flag_o    (flags4[gi])
      );
    end
  endgenerate

  // software sees one byte of flags
  // packed byte view; reserved bits tied low
  wire logic [7:0] flags = {2'b00, flags4[3], 2'b00, flags4[2:0]};

  // ---------------------------------------------------------------
  // vector requests
  // ---------------------------------------------------------------
  wire logic [3:0] en4 = {enables[tmrirq_pkg::BIT_CAPT], enables[tmrirq_pkg::BIT_CMPB],
                          enables[tmrirq_pkg::BIT_CMPA], enables[tmrirq_pkg::BIT_OVF]};
  // from registered flags, so a request trails its flag by one cycle
  wire logic [3:0] req_now = flags4 & en4 & {4{gie}};

  // registered outputs
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      vec_req_o <= '0;
      irq_o     <= 1'b0;
    end
    else
    begin
      vec_req_o <= req_now;
      irq_o     <= |req_now;
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  // reads decode the live address, no latch
  wire logic [7:0] rd_addr = {s_axi_araddr[7:2], 2'b00};
  wire logic rd_hit = (rd_addr == tmrirq_pkg::OFS_FLAGS) | (rd_addr == tmrirq_pkg::OFS_ENABLES)
                    | (rd_addr == tmrirq_pkg::OFS_CTRL)  | (rd_addr == tmrirq_pkg::OFS_STATUS);
  wire logic [31:0] rd_mux =
      (rd_addr == tmrirq_pkg::OFS_FLAGS)   ? {24'h000000, flags}
    : (rd_addr == tmrirq_pkg::OFS_ENABLES) ? {24'h000000, enables}
    : (rd_addr == tmrirq_pkg::OFS_CTRL)    ? {24'h000000, wgm, 3'b000, gie}
    : (rd_addr == tmrirq_pkg::OFS_STATUS)  ? {28'h0000000, vec_req_o}
    : 32'h0000_0000;
  wire logic ar_take = s_axi_arvalid & s_axi_arready;

  // one read in flight; data registered at the address handshake
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= tmrirq_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_rvalid & ~ar_take;
      // data sampled at the address handshake
      if (ar_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_hit ? tmrirq_pkg::RESP_OKAY : tmrirq_pkg::RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // flag set timing
  AST_CMPA_NEXT: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    evt_i.cmp_a_eq |-> ##2 flags4[1]) else $error("compare-A flag not set");
  AST_CMPB_NEXT: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    evt_i.cmp_b_eq |-> ##2 flags4[2]) else $error("compare-B flag not set");
  AST_FORCE_A: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (force_cmp_a_strobe_i && !cmp_a_d && !flags4[1]) |=> !flags4[1])
    else $error("force strobe set compare-A flag");
  AST_FORCE_B: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (force_cmp_b_strobe_i && !cmp_b_d && !flags4[2]) |=> !flags4[2])
    else $error("force strobe set compare-B flag");
  AST_CAPT_PIN: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (evt_i.capt_pin && !icr_top) |=> flags4[3]) else $error("capture flag missed");
  AST_CAPT_TOP: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (icr_top && evt_i.capt_pin && !evt_i.at_top && !flags4[3]) |=> !flags4[3])
    else $error("pin capture active in top mode");
  AST_OVF_WRAP: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (wrap_mode && evt_i.wrap) |=> flags4[0]) else $error("overflow flag missed");
  // clear paths
  AST_ACK_CLR: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (ack_i.ovf && !ovf_evt) |=> !flags4[0]) else $error("ack did not clear overflow");
  AST_ACK_CMPA: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (ack_i.cmp_a && !cmp_a_d) |=> !flags4[1])
    else $error("ack did not clear compare-A");
  AST_ACK_CMPB: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (ack_i.cmp_b && !cmp_b_d) |=> !flags4[2])
    else $error("ack did not clear compare-B");
  AST_ACK_CAPT: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (ack_i.capt && !capt_evt) |=> !flags4[3])
    else $error("ack did not clear capture");
  AST_W0_KEEP: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (wr_flg && !w_data[tmrirq_pkg::BIT_CAPT] && !ack_i.capt && flags4[3]) |=> flags4[3])
    else $error("zero write cleared capture flag");
  AST_ACK_OWN: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (ack_i == 4'h1 && !wr_flg && flags4[1]) |=> flags4[1])
    else $error("ack cleared another flag");
  // vector gating; reserved flag bits read zero
  AST_REQ_GATE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    vec_req_o[1] |-> $past(gie) && $past(en4[1]) && $past(flags4[1]))
    else $error("compare-A request without cause");
  AST_REQ_OVF: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (gie && en4[0] && flags4[0]) |=> vec_req_o[0]) else $error("overflow request missing");
  AST_REQ_CAPT: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    vec_req_o[3] |-> $past(gie) && $past(en4[3]) && $past(flags4[3]))
    else $error("capture request ungated");
  AST_REQ_CMPB: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    vec_req_o[2] |-> $past(gie) && $past(en4[2]) && $past(flags4[2]))
    else $error("compare-B request ungated");
  AST_IRQ_CAUSE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    irq_o |-> $past(gie) && ($past(flags4 & en4) != 4'h0))
    else $error("interrupt without enabled flag");
  AST_RSV_ZERO: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (s_axi_rvalid && $past(ar_take) && $past(rd_addr) == tmrirq_pkg::OFS_FLAGS)
    |-> s_axi_rdata[7:6] == 2'b00 && s_axi_rdata[4:3] == 2'b00)
    else $error("reserved flag bits read nonzero");

  // coverage of the main scenarios
  COV_IRQ:   cover property (@(posedge ref_clk_i) disable iff (!nrst_i) $rose(irq_o));
  COV_RACE:  cover property (@(posedge ref_clk_i) disable iff (!nrst_i) set_v[3] && clr_v[3]);
  COV_ACK:   cover property (@(posedge ref_clk_i) disable iff (!nrst_i) ack_i != 4'h0);
  COV_W1C:   cover property (@(posedge ref_clk_i) disable iff (!nrst_i) wr_flg && |w1c_v);
  COV_TOPCP: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) icr_top && capt_evt);
endmodule

// File: verification/tmrirq_core_model.sv
// processor core model: answers vector requests with acknowledge pulses
`timescale 1ns/1ps
module tmrirq_core_model
(
  input  wire logic                    ref_clk_i,
  input  wire logic                    nrst_i,
  input  wire logic                    en_i,      // core accepts vectors
  input  wire tmrirq_pkg::tmrirq_ack_t vec_req_i,
  output tmrirq_pkg::tmrirq_ack_t      ack_o
);
  logic [3:0] gap;  // hold-off so the request can drop first
  logic [3:0] pick; // lowest pending request wins, like a fixed-priority core

  assign pick = vec_req_i & (~vec_req_i + 4'h1);

  // ---------------------------------------------------------------
  // acknowledge one vector, then wait before taking the next
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ack_o <= '0;
      gap   <= 4'h0;
    end
    else if (gap != 4'h0)
    begin
      ack_o <= '0;          // acknowledge is a single-cycle pulse
      gap   <= gap - 4'h1;
    end
    else if (en_i && (vec_req_i != '0))
    begin
      ack_o <= pick;
      gap   <= 4'h8;
    end
  end
endmodule

// File: verification/tmrirq_top_test.sv
// self-checking bench for the timer irq flag block
`timescale 1ns/1ps
module tmrirq_top_test;
  // ---------------------------------------------------------------
  // nets towards the block
  // ---------------------------------------------------------------
  logic                    ref_clk_i;
  logic                    nrst_i;
  tmrirq_pkg::tmrirq_evt_t evt_i;
  logic                    force_cmp_a_strobe_i;
  logic                    force_cmp_b_strobe_i;
  tmrirq_pkg::tmrirq_ack_t ack_i;
  tmrirq_pkg::tmrirq_ack_t vec_req_o;
  logic                    irq_o;
  logic                    core_en;  // lets the core model take vectors
  logic [7:0]              s_axi_awaddr, s_axi_araddr;
  logic [31:0]             s_axi_wdata, s_axi_rdata;
  logic [3:0]              s_axi_wstrb;
  logic [1:0]              s_axi_bresp, s_axi_rresp;
  logic                    s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                    s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                    s_axi_rvalid, s_axi_rready;
  int                      error_cnt, total_checks, cyc;

  tmrirq_top dut_u (.ref_clk_i, .nrst_i, .evt_i, .force_cmp_a_strobe_i, .force_cmp_b_strobe_i,
    .ack_i, .vec_req_o, .irq_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  tmrirq_core_model core_u (.ref_clk_i, .nrst_i, .en_i(core_en), .vec_req_i(vec_req_o),
    .ack_o(ack_i));

  // ---------------------------------------------------------------
  // clock and hang guard: tests need well under a thousand cycles
  // ---------------------------------------------------------------
  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      final_report();
    end
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // master holds each channel until its own ready, bready until bvalid
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge ref_clk_i);
      n++;
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid && n < 100);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    chk_val("write answered", 1, n < 100);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge ref_clk_i);
      n++;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid && n < 100);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk_val("read answered", 1, n < 100);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk_val("bresp", tmrirq_pkg::RESP_OKAY, r);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk_val(nm, e, d);
    chk_val("rresp", tmrirq_pkg::RESP_OKAY, r);
  endtask
  task automatic pulse(input logic [5:0] e);
    @(posedge ref_clk_i);
    evt_i <= e;
    @(posedge ref_clk_i);
    evt_i <= '0;
  endtask
  // bounded wait until the request vector shows the given value
  task automatic wait_req(input logic [3:0] v);
    int n;
    n = 0;
    do
    begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    while (vec_req_o !== v && n < 60);
    chk_val("req wait", v, vec_req_o);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    rd_chk("flags rst", tmrirq_pkg::OFS_FLAGS, 0);
    rd_chk("enables rst", tmrirq_pkg::OFS_ENABLES, 0);
    rd_chk("ctrl rst", tmrirq_pkg::OFS_CTRL, 0);
    axi_rd(8'h10, d, r);
    chk_val("unmapped rresp", tmrirq_pkg::RESP_SLVERR, r);
    axi_wr(8'h10, 32'hFF, r);
    chk_val("unmapped bresp", tmrirq_pkg::RESP_SLVERR, r);
    $display("test reset done");
  endtask
  task automatic t_flags();
    @(posedge ref_clk_i);
    force_cmp_a_strobe_i <= 1'b1;
    force_cmp_b_strobe_i <= 1'b1;
    @(posedge ref_clk_i);
    force_cmp_a_strobe_i <= 1'b0;
    force_cmp_b_strobe_i <= 1'b0;
    rd_chk("flags force", tmrirq_pkg::OFS_FLAGS, 0);
    pulse(6'h2E);
    rd_chk("flags set", tmrirq_pkg::OFS_FLAGS, 32'h27);
    wr(tmrirq_pkg::OFS_FLAGS, 32'h00);
    rd_chk("flags w0", tmrirq_pkg::OFS_FLAGS, 32'h27);
    wr(tmrirq_pkg::OFS_FLAGS, 32'h02);
    rd_chk("flags w1 one", tmrirq_pkg::OFS_FLAGS, 32'h25);
    wr(tmrirq_pkg::OFS_FLAGS, 32'hFF);
    rd_chk("flags w1 all", tmrirq_pkg::OFS_FLAGS, 0);
    wr(tmrirq_pkg::OFS_CTRL, {24'h0, tmrirq_pkg::WGM_CTC_OCRA, 4'h0});
    rd_chk("ctrl wr", tmrirq_pkg::OFS_CTRL, {24'h0, tmrirq_pkg::WGM_CTC_OCRA, 4'h0});
    pulse(6'h02);
    rd_chk("flags ovf ctc", tmrirq_pkg::OFS_FLAGS, 32'h01);
    wr(tmrirq_pkg::OFS_FLAGS, 32'h01);
    // capture pin event lands on the commit edge of a write-one clear
    fork
      wr(tmrirq_pkg::OFS_FLAGS, 32'h20);
      begin
        repeat (2) @(posedge ref_clk_i);
        evt_i <= 6'h20;
        @(posedge ref_clk_i);
        evt_i <= '0;
      end
    join
    rd_chk("set beats clear", tmrirq_pkg::OFS_FLAGS, 32'h20);
    wr(tmrirq_pkg::OFS_FLAGS, 32'h20);
    $display("test flags done");
  endtask
  task automatic t_captop();
    logic [3:0] m [4];
    logic [7:0] tp [4];
    logic [7:0] bt [4];
    m = '{tmrirq_pkg::WGM_PFC_ICR, tmrirq_pkg::WGM_PC_ICR, tmrirq_pkg::WGM_CTC_ICR,
          tmrirq_pkg::WGM_FAST_ICR};
    tp = '{8'h20, 8'h20, 8'h20, 8'h21};  // fast mode also flags overflow at top
    bt = '{8'h01, 8'h01, 8'h00, 8'h00};  // phase-correct modes flag overflow at bottom
    foreach (m[i])
    begin
      wr(tmrirq_pkg::OFS_CTRL, {24'h0, m[i], 4'h0});
      pulse(6'h20);
      rd_chk("capt pin off", tmrirq_pkg::OFS_FLAGS, 0);
      pulse(6'h10);
      rd_chk("capt at top", tmrirq_pkg::OFS_FLAGS, tp[i]);
      pulse(6'h01);
      rd_chk("ovf at bottom", tmrirq_pkg::OFS_FLAGS, tp[i] | bt[i]);
      wr(tmrirq_pkg::OFS_FLAGS, 32'hFF);
    end
    wr(tmrirq_pkg::OFS_CTRL, 0);
    $display("test capture top done");
  endtask
  task automatic t_vec();
    logic [5:0] ev [4];
    logic [3:0] rq [4];
    int         dl [4];
    ev = '{6'h20, 6'h08, 6'h04, 6'h02};
    rq = '{4'h8, 4'h2, 4'h4, 4'h1};
    dl = '{1, 2, 2, 1};  // pin and wrap set at once, compares one cycle later
    wr(tmrirq_pkg::OFS_ENABLES, 32'hFF);
    rd_chk("enables", tmrirq_pkg::OFS_ENABLES, 32'h27);
    wr(tmrirq_pkg::OFS_CTRL, 32'h01);
    foreach (ev[i])
    begin
      pulse(ev[i]);
      #1;
      chk_val("req early", 0, vec_req_o);
      repeat (dl[i]) @(posedge ref_clk_i);
      #1;
      chk_val("req", rq[i], vec_req_o);
      chk_val("irq", 1, irq_o);
      rd_chk("status", tmrirq_pkg::OFS_STATUS, rq[i]);
      core_en = 1'b1;
      wait_req(4'h0);
      core_en = 1'b0;
      rd_chk("flags acked", tmrirq_pkg::OFS_FLAGS, 0);
    end
    wr(tmrirq_pkg::OFS_CTRL, 0);
    pulse(6'h2E);
    repeat (4) @(posedge ref_clk_i);
    #1;
    chk_val("req no gie", 0, vec_req_o);
    chk_val("irq no gie", 0, irq_o);
    wr(tmrirq_pkg::OFS_CTRL, 32'h01);
    core_en = 1'b1;
    wait_req(4'hE);
    core_en = 1'b0;
    rd_chk("ack own only", tmrirq_pkg::OFS_FLAGS, 32'h26);
    wr(tmrirq_pkg::OFS_FLAGS, 32'hFF);
    $display("test vectors done");
  endtask

  // ---------------------------------------------------------------
  // verdict and main sequence
  // ---------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    {nrst_i, evt_i, force_cmp_a_strobe_i, force_cmp_b_strobe_i, core_en} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;  // only byte lane 0 carries register bits
    {error_cnt, total_checks, cyc} = '0;
    repeat (10) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    t_reset();
    t_flags();
    t_captop();
    t_vec();
    final_report();
  end
endmodule
